// ### hdl/mhf_pkg.sv
// Shared constants, field layout and header check arithmetic
package mhf_pkg;
	// Frame control byte layout
	localparam int FRAME_TYPE_CODE_HI = 7;
	localparam int FRAME_TYPE_CODE_LO = 6;
	localparam int FRAME_PARAMETER_BITS_HI = 5;
	localparam int FRAME_PARAMETER_BITS_LO = 1;
	localparam int FC_EXTENDED_HEADER_BIT = 0;
	// Frame type codes
	localparam logic [1:0] TYPE_PACKET = 2'h0;
	localparam logic [1:0] TYPE_ATM = 2'h1;
	localparam logic [1:0] TYPE_RSVD = 2'h2;
	localparam logic [1:0] TYPE_MAC = 2'h3;
	// Parameter bit codes within control headers
	localparam logic [4:0] PARM_REQUEST = 5'h02;
	localparam logic [4:0] PARM_CONCAT = 5'h1C;
	localparam logic [4:0] PARM_STUFF = 5'h1F;
	// Convergence stuffing pattern and extended header limit
	localparam logic [7:0] STUFF_BYTE = 8'hFF;
	localparam logic [7:0] EXT_MAX = 8'hF0;
	// Header check sequence generator
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	// Serial and counting constants
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] HDR_LAST = 2'h3;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// Framer register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_HDR = 4'h0;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	// Field positions in the header and status words
	localparam int HW_FC_LO = 24;
	localparam int HW_PARM_LO = 16;
	localparam int HW_LEN_LO = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_DBUF = 1;
	localparam int ST_REJ = 2;
	localparam int ST_CNT_LO = 16;

	// One byte through the check sequence, high bit first
	function automatic logic [15:0] mhf_crc_byte(input logic [15:0] crc,
		input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ data[i]) begin
				c = {c[14:0], 1'h0} ^ CRC_POLY;
			end else begin
				c = {c[14:0], 1'h0};
			end
		end
		return c;
	endfunction
endpackage

// ### hdl/mhf_link_if.sv
// Serial upstream link between the framer and the parser
`timescale 1ns/1ps
interface mhf_link_if;
	logic link_bit; // Serial data, low bit of each octet first
	logic link_valid; // Bit lane carries a bit this cycle
	logic link_sof; // First bit of a frame
	modport framer (output link_bit, output link_valid, output link_sof);
	modport parser (input link_bit, input link_valid, input link_sof);
endinterface

// ### hdl/mhf_framer.sv
// Header framer and serializer with an Avalon-MM command port
`timescale 1ns/1ps
module mhf_framer
	import mhf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	mhf_link_if.framer link,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum logic [4:0] {
		FR_IDLE = 5'h01,
		FR_HDR = 5'h02,
		FR_EXT = 5'h04,
		FR_HCS = 5'h08,
		FR_PAY = 5'h10
	} mhf_fr_state_t;

	mhf_fr_state_t state_r; // Frame sequencer
	logic [31:0] hdr_r; // Header word in flight
	logic [15:0] crc_r; // Running check sequence
	logic [1:0] hcnt_r; // Byte index in fixed header or check field
	logic [15:0] sec_r; // Bytes left in current section
	logic [7:0] dbuf_r; // Holding byte from the bus
	logic dbuf_full_r; // Holding byte valid
	logic rej_r; // Last header word refused
	logic [7:0] sh_r; // Output shifter
	logic [3:0] bits_r; // Bits left in shifter
	logic first_r; // Next emitted bit opens a frame
	logic bit_r, valid_r, sof_r; // Link drivers
	logic wait_r; // Bus wait state

	// Fields of the header word
	wire [7:0] h_fc = hdr_r[HW_FC_LO +: 8];
	wire [7:0] h_parm = hdr_r[HW_PARM_LO +: 8];
	wire [15:0] h_len = hdr_r[HW_LEN_LO +: 16];
	wire [7:0] h_ext_header_length = h_fc[FC_EXTENDED_HEADER_BIT] ? h_parm : 8'h00;
	wire h_is_req = (h_fc[FRAME_TYPE_CODE_HI:FRAME_TYPE_CODE_LO] == TYPE_MAC) &&
		(h_fc[FRAME_PARAMETER_BITS_HI:FRAME_PARAMETER_BITS_LO] == PARM_REQUEST);
	// Length covers extension plus payload; negative means no payload
	wire [16:0] h_diff = {1'h0, h_len} - {9'h000, h_ext_header_length};
	wire [15:0] h_pay = (h_is_req || h_diff[16]) ? 16'h0000 :
		h_diff[15:0];

	// Bus decode
	wire req = avs_read || avs_write;
	wire sel_hdr = (avs_address == OFS_HDR);
	wire sel_data = (avs_address == OFS_DATA);
	wire sel_stat = (avs_address == OFS_STAT);
	wire idle = (state_r == FR_IDLE);
	wire hold = avs_write && !idle && (sel_hdr || (sel_data && dbuf_full_r));
	wire acc = req && !wait_r;
	wire [7:0] wd_fc = avs_writedata[HW_FC_LO +: 8];
	wire [7:0] wd_parm = avs_writedata[HW_PARM_LO +: 8];
	// Stuff-pattern control code and oversize extension are refused
	wire wd_bad = ((wd_fc[FRAME_TYPE_CODE_HI:FRAME_TYPE_CODE_LO] == TYPE_MAC) &&
		(wd_fc[FRAME_PARAMETER_BITS_HI:FRAME_PARAMETER_BITS_LO] == PARM_STUFF)) ||
		(wd_fc[FC_EXTENDED_HEADER_BIT] && (wd_parm > EXT_MAX));
	wire hdr_go = acc && avs_write && sel_hdr;
	wire data_go = acc && avs_write && sel_data && !idle;
	wire [31:0] stat_w = {sec_r, 13'h0000, rej_r, dbuf_full_r, !idle};
	wire [31:0] rd_val = sel_hdr ? hdr_r : (sel_stat ? stat_w : 32'h0000_0000);

	// Byte selection: fixed header high length octet first, check high first
	wire [7:0] hdr_byte = (hcnt_r == 2'h0) ? h_fc :
		(hcnt_r == 2'h1) ? h_parm :
		(hcnt_r == 2'h2) ? h_len[15:8] : h_len[7:0];
	wire [7:0] hcs_byte = hcnt_r[0] ? crc_r[7:0] : crc_r[15:8];
	wire from_bus = (state_r == FR_EXT) || (state_r == FR_PAY);
	wire [7:0] ld_byte = (state_r == FR_HDR) ? hdr_byte :
		(state_r == FR_HCS) ? hcs_byte : dbuf_r;
	wire ld_avail = (state_r == FR_HDR) || (state_r == FR_HCS) ||
		(from_bus && dbuf_full_r);
	wire ld = (bits_r <= 4'h1) && ld_avail;
	wire [15:0] crc_next = mhf_crc_byte(crc_r, ld_byte);
	wire sec_last = (sec_r == CNT_ONE);

	assign avs_waitrequest = wait_r;
	assign link.link_bit = bit_r;
	assign link.link_valid = valid_r;
	assign link.link_sof = sof_r;

	// Bus slave: one wait cycle, more while a write is held off; action at the edge with wait low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_r <= 1'h1;
			avs_readdata <= 32'h0000_0000;
		end else if (wait_r && req && !hold) begin
			wait_r <= 1'h0;
			avs_readdata <= rd_val;
		end else begin
			wait_r <= 1'h1;
		end
	end

	// Holding byte for extension and payload data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dbuf_r <= 8'h00;
			dbuf_full_r <= 1'h0;
		end else if (data_go) begin
			dbuf_r <= avs_writedata[7:0];
			dbuf_full_r <= 1'h1;
		end else if (ld && from_bus) begin
			dbuf_full_r <= 1'h0;
		end
	end

	// Frame sequencer: header, extension, check field, payload
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= FR_IDLE;
			hdr_r <= 32'h0000_0000;
			crc_r <= CRC_INIT;
			hcnt_r <= 2'h0;
			sec_r <= 16'h0000;
			rej_r <= 1'h0;
		end else begin
			if (hdr_go) begin
				rej_r <= wd_bad;
			end
			if (hdr_go && !wd_bad) begin
				hdr_r <= avs_writedata;
				state_r <= FR_HDR;
				crc_r <= CRC_INIT;
				hcnt_r <= 2'h0;
			end
			if (ld) begin
				case (state_r)
					FR_HDR: begin
						crc_r <= crc_next;
						hcnt_r <= hcnt_r + 2'h1;
						if (hcnt_r == HDR_LAST) begin
							hcnt_r <= 2'h0;
							sec_r <= {8'h00, h_ext_header_length};
							state_r <= (h_ext_header_length != 8'h00) ? FR_EXT : FR_HCS;
						end
					end
					FR_EXT: begin
						crc_r <= crc_next;
						sec_r <= sec_r - CNT_ONE;
						if (sec_last) begin
							state_r <= FR_HCS;
						end
					end
					FR_HCS: begin
						hcnt_r <= hcnt_r + 2'h1;
						if (hcnt_r[0]) begin
							sec_r <= h_pay;
							state_r <= (h_pay != 16'h0000) ? FR_PAY : FR_IDLE;
						end
					end
					FR_PAY: begin
						sec_r <= sec_r - CNT_ONE;
						if (sec_last) begin
							state_r <= FR_IDLE;
						end
					end
					default: state_r <= FR_IDLE;
				endcase
			end
		end
	end

	// Serializer: low bit first, start marked on the first bit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sh_r <= 8'h00;
			bits_r <= 4'h0;
			first_r <= 1'h0;
			bit_r <= 1'h0;
			valid_r <= 1'h0;
			sof_r <= 1'h0;
		end else begin
			if (bits_r != 4'h0) begin
				bit_r <= sh_r[0];
				valid_r <= 1'h1;
				sof_r <= first_r;
				sh_r <= {1'h0, sh_r[7:1]};
				bits_r <= bits_r - 4'h1;
				first_r <= 1'h0;
			end else begin
				valid_r <= 1'h0;
				sof_r <= 1'h0;
			end
			if (ld) begin
				sh_r <= ld_byte;
				bits_r <= BYTE_BITS;
				if ((state_r == FR_HDR) && (hcnt_r == 2'h0)) begin
					first_r <= 1'h1;
				end
			end
		end
	end
endmodule

// ### hdl/mhf_parser.sv
// Header parser: deserializes, checks and splits received frames
//
// Chosen here: the output strobe ports; the register offsets and the Avalon-MM slave port belong to the framer.
`timescale 1ns/1ps
module mhf_parser
	import mhf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	mhf_link_if.parser link,
	output logic frame_start,
	output logic hdr_ok,
	output logic hdr_err,
	output logic [7:0] hdr_control,
	output logic [7:0] hdr_param,
	output logic [15:0] hdr_len_sid,
	output logic hdr_is_request,
	output logic ext_valid,
	output logic [7:0] ext_data,
	output logic [7:0] ext_tlv_type,
	output logic ext_is_value,
	output logic pay_valid,
	output logic [7:0] pay_data,
	output logic pay_last
);
	typedef enum logic [8:0] {
		PR_HUNT = 9'h001,
		PR_PARM = 9'h002,
		PR_LENH = 9'h004,
		PR_LENL = 9'h008,
		PR_EXT = 9'h010,
		PR_HCSH = 9'h020,
		PR_HCSL = 9'h040,
		PR_PAY = 9'h080,
		PR_SKIP = 9'h100
	} mhf_pr_state_t;

	typedef enum logic [2:0] {
		TL_TYPE = 3'h1,
		TL_LEN = 3'h2,
		TL_VAL = 3'h4
	} mhf_tlv_t;

	logic [7:0] sh_r; // Deserializer shifter
	logic [2:0] bcnt_r; // Bits gathered in current octet
	logic first_pend_r; // Frame start seen, octet not yet complete
	logic [7:0] byte_r; // Completed octet
	logic byte_stb_r; // Completed octet strobe
	logic byte_first_r; // Completed octet opens a frame
	mhf_pr_state_t state_r; // Header walk
	mhf_tlv_t tlv_r; // Tuple walk in the extension
	logic [7:0] tlv_left_r; // Value bytes left in tuple
	logic [7:0] tlv_type_r; // Current tuple type
	logic [7:0] fc_r, parm_r; // Header bytes under check
	logic [15:0] len_r; // Third field under check
	logic [7:0] hcs_hi_r; // Received check high octet
	logic [15:0] crc_r; // Running check sequence
	logic [15:0] cnt_r; // Bytes left in section

	// Decoded header fields
	wire [1:0] f_type = fc_r[FRAME_TYPE_CODE_HI:FRAME_TYPE_CODE_LO];
	wire [4:0] f_parm = fc_r[FRAME_PARAMETER_BITS_HI:FRAME_PARAMETER_BITS_LO];
	wire f_ext = fc_r[FC_EXTENDED_HEADER_BIT];
	wire [7:0] f_ext_header_length = f_ext ? parm_r : 8'h00;
	wire f_req = (f_type == TYPE_MAC) && (f_parm == PARM_REQUEST);
	// ATM and reserved payloads are walked over, not delivered
	wire f_discard = (f_type == TYPE_ATM) || (f_type == TYPE_RSVD);
	wire [16:0] f_diff = {1'h0, len_r} - {9'h000, f_ext_header_length};
	wire [15:0] f_pay = (f_req || f_diff[16]) ? 16'h0000 :
		f_diff[15:0];
	wire [15:0] crc_next = mhf_crc_byte(crc_r, byte_r);
	wire [15:0] crc_first = mhf_crc_byte(CRC_INIT, byte_r);
	wire hcs_good = ({hcs_hi_r, byte_r} == crc_r);
	wire is_stuff = (byte_r == STUFF_BYTE);
	wire at_fc = byte_first_r || (state_r == PR_HUNT);
	wire cnt_last = (cnt_r == CNT_ONE);
	wire [7:0] lenh_hold = len_r[15:8];

	// Deserializer: octet gathered low bit first, start flag carried
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sh_r <= 8'h00;
			bcnt_r <= 3'h0;
			first_pend_r <= 1'h0;
			byte_r <= 8'h00;
			byte_stb_r <= 1'h0;
			byte_first_r <= 1'h0;
		end else begin
			byte_stb_r <= 1'h0;
			if (link.link_valid) begin
				sh_r <= {link.link_bit, sh_r[7:1]};
				if (link.link_sof) begin
					bcnt_r <= 3'h1;
					first_pend_r <= 1'h1;
				end else begin
					bcnt_r <= bcnt_r + 3'h1;
				end
				if ((bcnt_r == BIT_LAST) && !link.link_sof) begin
					byte_r <= {link.link_bit, sh_r[7:1]};
					byte_stb_r <= 1'h1;
					byte_first_r <= first_pend_r;
					first_pend_r <= 1'h0;
				end
			end
		end
	end

	// Header walk, check, and payload steering
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_r <= PR_HUNT;
			fc_r <= 8'h00;
			parm_r <= 8'h00;
			len_r <= 16'h0000;
			hcs_hi_r <= 8'h00;
			crc_r <= CRC_INIT;
			cnt_r <= 16'h0000;
			frame_start <= 1'h0;
			hdr_ok <= 1'h0;
			hdr_err <= 1'h0;
			hdr_control <= 8'h00;
			hdr_param <= 8'h00;
			hdr_len_sid <= 16'h0000;
			hdr_is_request <= 1'h0;
			pay_valid <= 1'h0;
			pay_data <= 8'h00;
			pay_last <= 1'h0;
		end else begin
			frame_start <= 1'h0;
			hdr_ok <= 1'h0;
			hdr_err <= 1'h0;
			pay_valid <= 1'h0;
			pay_last <= 1'h0;
			if (byte_stb_r && at_fc) begin
				if (is_stuff) begin
					state_r <= PR_HUNT;
				end else begin
					fc_r <= byte_r;
					crc_r <= crc_first;
					frame_start <= 1'h1;
					state_r <= PR_PARM;
				end
			end else if (byte_stb_r) begin
				case (state_r)
					PR_PARM: begin
						parm_r <= byte_r;
						crc_r <= crc_next;
						if (f_ext && (byte_r > EXT_MAX)) begin
							hdr_err <= 1'h1;
							state_r <= PR_HUNT;
						end else begin
							state_r <= PR_LENH;
						end
					end
					PR_LENH: begin
						len_r <= {byte_r, len_r[7:0]};
						crc_r <= crc_next;
						state_r <= PR_LENL;
					end
					PR_LENL: begin
						len_r <= {lenh_hold, byte_r};
						crc_r <= crc_next;
						cnt_r <= {8'h00, f_ext_header_length};
						state_r <= (f_ext_header_length != 8'h00) ? PR_EXT : PR_HCSH;
					end
					PR_EXT: begin
						crc_r <= crc_next;
						cnt_r <= cnt_r - CNT_ONE;
						if (cnt_last) begin
							state_r <= PR_HCSH;
						end
					end
					PR_HCSH: begin
						hcs_hi_r <= byte_r;
						state_r <= PR_HCSL;
					end
					PR_HCSL: begin
						if (!hcs_good) begin
							hdr_err <= 1'h1;
							state_r <= PR_HUNT;
						end else begin
							hdr_ok <= 1'h1;
							hdr_control <= fc_r;
							hdr_param <= parm_r;
							hdr_len_sid <= len_r;
							hdr_is_request <= f_req;
							cnt_r <= f_pay;
							if (f_pay == 16'h0000) begin
								state_r <= PR_HUNT;
							end else if (f_discard) begin
								state_r <= PR_SKIP;
							end else begin
								state_r <= PR_PAY;
							end
						end
					end
					PR_PAY: begin
						pay_valid <= 1'h1;
						pay_data <= byte_r;
						pay_last <= cnt_last;
						cnt_r <= cnt_r - CNT_ONE;
						if (cnt_last) begin
							state_r <= PR_HUNT;
						end
					end
					PR_SKIP: begin
						cnt_r <= cnt_r - CNT_ONE;
						if (cnt_last) begin
							state_r <= PR_HUNT;
						end
					end
					default: state_r <= PR_HUNT;
				endcase
			end
		end
	end

	// Extension forwarding with a tuple walk; no tuple type is an error
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tlv_r <= TL_TYPE;
			tlv_left_r <= 8'h00;
			tlv_type_r <= 8'h00;
			ext_valid <= 1'h0;
			ext_data <= 8'h00;
			ext_tlv_type <= 8'h00;
			ext_is_value <= 1'h0;
		end else begin
			ext_valid <= 1'h0;
			if (byte_stb_r && !at_fc && (state_r == PR_LENL)) begin
				tlv_r <= TL_TYPE;
			end
			if (byte_stb_r && !at_fc && (state_r == PR_EXT)) begin
				ext_valid <= 1'h1;
				ext_data <= byte_r;
				ext_is_value <= (tlv_r == TL_VAL);
				case (tlv_r)
					TL_TYPE: begin
						tlv_type_r <= byte_r;
						ext_tlv_type <= byte_r;
						tlv_r <= TL_LEN;
					end
					TL_LEN: begin
						tlv_left_r <= byte_r;
						ext_tlv_type <= tlv_type_r;
						// Zero length is legal for extension elements
						tlv_r <= (byte_r == 8'h00) ? TL_TYPE : TL_VAL;
					end
					TL_VAL: begin
						// Value bytes pass through whatever the type
						ext_tlv_type <= tlv_type_r;
						tlv_left_r <= tlv_left_r - 8'h01;
						if (tlv_left_r == 8'h01) begin
							tlv_r <= TL_TYPE;
						end
					end
					default: tlv_r <= TL_TYPE;
				endcase
			end
		end
	end
endmodule

// ### tb/mhf_sva.sv
// Checker of the serial link between framer and parser
`timescale 1ns/1ps
module mhf_sva
	import mhf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic link_bit,
	input wire logic link_valid,
	input wire logic link_sof
);
	logic [2:0] nb_r; // Bit index within octet
	logic [6:0] sh_r; // Bits of octet so far, low first
	logic [3:0] oi_r; // Octet index in frame, saturating
	logic [7:0] fc_r; // Control byte of frame
	logic [15:0] crc_r; // Own check over the four fixed bytes
	wire [2:0] nb = link_sof ? 3'h0 : nb_r;
	wire [3:0] oi = link_sof ? 4'h0 : oi_r;
	wire [7:0] oct = {link_bit, sh_r};
	wire done = link_valid && nb == BIT_LAST;
	// Check step kept apart from the design's own function
	function automatic logic [15:0] ck(input logic [15:0] c,
		input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
		end
		return c;
	endfunction
	// Assemble octets as they pass
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			nb_r <= 3'h0;
			oi_r <= 4'h0;
		end else if (link_valid) begin
			nb_r <= nb + 3'h1;
			sh_r <= {link_bit, sh_r[6:1]};
			oi_r <= (done && oi != 4'hF) ? oi + 4'h1 : oi;
			if (done && oi == 4'h0) begin
				fc_r <= oct;
				crc_r <= ck(16'hFFFF, oct);
			end else if (done && oi < 4'h4) begin
				crc_r <= ck(crc_r, oct);
			end
		end
	end
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence fc_bits;
		link_valid [*7];
	endsequence
	sof_valid_a: assert property (link_sof |-> link_valid)
		else $error("frame start without a valid bit");
	sof_align_a: assert property (link_sof |-> nb_r == 3'h0)
		else $error("frame start inside an octet");
	sof_pulse_a: assert property (link_sof |=> !link_sof)
		else $error("frame start longer than one bit");
	fc_run_a: assert property (link_sof |=> fc_bits)
		else $error("control octet bits not continuous");
	fc_stuff_a: assert property (done && oi == 4'h0 |-> oct != 8'hFF)
		else $error("stuff pattern sent as control byte");
	ext_len_a: assert property (done && oi == 4'h1 && fc_r[0]
		|-> oct <= 8'hF0)
		else $error("extended header too long");
	hcs_hi_a: assert property (done && oi == 4'h4 && !fc_r[0]
		|-> oct == crc_r[15:8])
		else $error("check high octet wrong");
	hcs_lo_a: assert property (done && oi == 4'h5 && !fc_r[0]
		|-> oct == crc_r[7:0])
		else $error("check low octet wrong");
endmodule

// ### tb/tb.sv
// Bench: framer feeds parser; a second parser sees a faulty driver
`timescale 1ns/1ps
module tb
	import mhf_pkg::*;
;
	logic ref_clk = 1'h0; // 10 MHz clock
	logic rst_n = 1'h0; // Synchronous reset, active low
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic frame_start, hdr_ok, hdr_err, hdr_is_request;
	logic ext_valid, ext_is_value, pay_valid, pay_last;
	logic [7:0] hdr_control, hdr_param, ext_tlv_type, pay_data;
	logic [15:0] hdr_len_sid;
	logic fs2, ok2, err2; // Second parser pulses
	int n_ok, n_err, n_fs, n_ext, n_last, n_fs2, n_ok2, n_err2, cyc;
	int bad_count, num_checks;
	logic [7:0] pay_q[$]; // Payload bytes seen
	logic [7:0] tlv_seen; // Tuple type at last value byte
	logic [7:0] ext_byte; // Extension byte lane from the parser
	logic [7:0] val_seen; // Last extension value byte
	logic [31:0] q;
	mhf_link_if l1();
	mhf_link_if l2();
	mhf_framer i_mhf_framer(.ref_clk(ref_clk), .rst_n(rst_n), .link(l1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	mhf_parser i_mhf_parser(.ref_clk(ref_clk), .rst_n(rst_n), .link(l1),
		.frame_start(frame_start), .hdr_ok(hdr_ok), .hdr_err(hdr_err),
		.hdr_control(hdr_control), .hdr_param(hdr_param),
		.hdr_len_sid(hdr_len_sid), .hdr_is_request(hdr_is_request),
		.ext_valid(ext_valid), .ext_data(ext_byte),
		.ext_tlv_type(ext_tlv_type),
		.ext_is_value(ext_is_value), .pay_valid(pay_valid),
		.pay_data(pay_data), .pay_last(pay_last));
	mhf_parser i_mhf_parser_b(.ref_clk(ref_clk), .rst_n(rst_n), .link(l2),
		.frame_start(fs2), .hdr_ok(ok2), .hdr_err(err2), .hdr_control(),
		.hdr_param(), .hdr_len_sid(), .hdr_is_request(), .ext_valid(),
		.ext_data(), .ext_tlv_type(), .ext_is_value(), .pay_valid(),
		.pay_data(), .pay_last());
	mhf_sva i_mhf_sva(.ref_clk(ref_clk), .rst_n(rst_n),
		.link_bit(l1.link_bit), .link_valid(l1.link_valid),
		.link_sof(l1.link_sof));
	// Clock
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	// Count parser pulses and cut a hang short
	always @(posedge ref_clk) begin
		n_ok += hdr_ok;
		n_err += hdr_err;
		n_fs += frame_start;
		n_ext += ext_valid;
		n_last += pay_last;
		n_fs2 += fs2;
		n_ok2 += ok2;
		n_err2 += err2;
		if (pay_valid === 1'h1) begin
			pay_q.push_back(pay_data);
		end
		if (ext_valid && ext_is_value) begin
			tlv_seen = ext_tlv_type;
			val_seen = ext_byte;
		end
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
		r = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	// Send a header and its bytes, then wait for the link to go idle
	task automatic frame(input logic [31:0] hw, input logic [7:0] b[$]);
		logic [31:0] r;
		n_ok = 0;
		n_err = 0;
		n_ext = 0;
		n_last = 0;
		pay_q.delete();
		bus(1'h1, OFS_HDR, hw, r);
		foreach (b[i]) begin
			bus(1'h1, OFS_DATA, {24'h0, b[i]}, r);
		end
		do bus(1'h0, OFS_STAT, 32'h0, r); while (r[ST_BUSY] !== 1'h0);
		repeat (30) @(posedge ref_clk);
	endtask
	// Faulty driver: one octet on the second link, low bit first
	task automatic sb(input logic [7:0] v, input logic s);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			l2.link_valid <= 1'h1;
			l2.link_sof <= s && i == 0;
			l2.link_bit <= v[i];
		end
	endtask
	logic [7:0] ty[3] = '{TYPE_ATM, TYPE_RSVD, TYPE_MAC};
	initial begin
		l2.link_bit = 1'h0;
		l2.link_valid = 1'h0;
		l2.link_sof = 1'h0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		// Plain packet with two payload bytes
		frame(32'h0000_0002, '{8'hA5, 8'h3C});
		chk("hdr_ok", 32'h1, n_ok);
		chk("len", 32'h2, hdr_len_sid);
		chk("pay0", 32'hA5, pay_q[0]);
		chk("pay1", 32'h3C, pay_q[1]);
		chk("last", 32'h1, n_last);
		$display("test packet done");
		// Extension with one unknown tuple, then one payload byte
		frame(32'h0103_0004, '{8'h05, 8'h01, 8'h7E, 8'h99});
		chk("ext", 32'h3, n_ext);
		chk("tlv", 32'h05, tlv_seen);
		chk("tval", 32'h7E, val_seen);
		chk("err", 32'h0, n_err);
		chk("param", 32'h03, hdr_param);
		chk("pay", 32'h99, pay_q[0]);
		$display("test extension done");
		// Request header: field is a service identifier
		frame(32'hC405_1234, '{});
		chk("req", 32'h1, hdr_is_request);
		chk("sid", 32'h1234, hdr_len_sid);
		chk("npay", 32'h0, pay_q.size());
		bus(1'h0, OFS_HDR, 32'h0, q);
		chk("hdr_rd", 32'hC405_1234, q);
		$display("test request done");
		// Discarded and control types
		foreach (ty[i]) begin
			frame({ty[i][1:0], 6'h0, 24'h2}, '{8'h11, 8'h22});
			chk("ctrl", {ty[i][1:0], 6'h0}, hdr_control);
			chk("skip", ty[i] == TYPE_MAC ? 2 : 0, pay_q.size());
		end
		$display("test types done");
		// Refused headers and unmapped place
		bus(1'h1, OFS_HDR, 32'hFE00_0000, q);
		bus(1'h0, OFS_STAT, 32'h0, q);
		chk("rej_stuff", 32'h1, q[ST_REJ]);
		bus(1'h1, OFS_HDR, 32'h01F1_0000, q);
		bus(1'h0, OFS_STAT, 32'h0, q);
		chk("rej_len", 32'h1, q[ST_REJ]);
		bus(1'h0, 4'hC, 32'h0, q);
		chk("unmapped", 32'h0, q);
		$display("test refusals done");
		// Stuffing, then a header with a wrong check
		sb(8'hFF, 1'h0);
		sb(8'h00, 1'h1);
		repeat (5) sb(8'h00, 1'h0);
		@(posedge ref_clk);
		l2.link_valid <= 1'h0;
		l2.link_bit <= 1'h1;
		repeat (10) @(posedge ref_clk);
		chk("fs2", 32'h1, n_fs2);
		chk("err2", 32'h1, n_err2);
		chk("ok2", 32'h0, n_ok2);
		$display("test bad check done");
		complete_run();
	end
endmodule
